// file: core/ioc_pkg.sv
// package of register numbers, field positions and timing for input capture
package ioc_pkg;
  // register numbers on the register port
  localparam logic [15:0] REG_PRIMARY_CONFIG   = 16'h0065;
  localparam logic [15:0] REG_SECONDARY_CONFIG = 16'h006A;
  localparam logic [15:0] REG_PULSE_GEN_ONE    = 16'h047E;
  localparam logic [15:0] REG_ANALOG_ONE       = 16'h0480;
  localparam logic [15:0] REG_ANALOG_TWO       = 16'h0481;
  localparam logic [15:0] REG_ANALOG_THREE     = 16'h0482;
  localparam logic [15:0] REG_PULSE_GEN_TWO    = 16'h0483;
  localparam logic [15:0] REG_READ_INTERVAL    = 16'h0484;
  localparam logic [15:0] REG_INDEX_INTERVAL   = 16'h0485;
  localparam logic [15:0] REG_SWITCH_MATRIX    = 16'h0486;
  // primary config fields
  localparam int unsigned ANALOG_USE_POS       = 1;
  localparam logic [15:0] PRIMARY_RESET        = 16'h0002;
  // secondary config fields
  localparam int unsigned CHAN_ONE_USE_POS     = 0;
  localparam int unsigned CHAN_TWO_USE_POS     = 1;
  localparam int unsigned CHAN_ONE_FINE_POS    = 2;
  localparam int unsigned CHAN_TWO_FINE_POS    = 3;
  localparam int unsigned MATRIX_SCAN_POS      = 5;
  localparam int unsigned PERIOD_DISABLE_POS   = 6;
  localparam int unsigned SPINDLE_DISABLE_POS  = 7;
  localparam logic [15:0] SECONDARY_RESET      = 16'h000F;
  localparam logic [15:0] CONFIG_WRITE_MASK    = 16'h00EF;
  // analog result width
  localparam int unsigned ANALOG_WIDTH         = 10;
  // matrix column settle time
  localparam int unsigned SETTLE_NS            = 1000;
  localparam int unsigned CLK_PERIOD_NS        = 4;
  localparam int unsigned SETTLE_CYCLES        =
    (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  SETTLE_LAST          = 8'(SETTLE_CYCLES - 1);
  // one processor tick in system clocks
  localparam int unsigned TICK_NS              = 1000;
  localparam logic [7:0]  TICK_LAST            =
    8'(TICK_NS / CLK_PERIOD_NS - 1);
  // scanner states
  typedef enum logic [1:0] {
    SCAN_SETTLE = 2'b01,
    SCAN_SAMPLE = 2'b10
  } ioc_scan_type;
endpackage

// file: core/ioc_input_capture.sv
// input capture block: analog results, pulse counters, timers, switch matrix
module ioc_input_capture
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  input  wire logic        i_reg_rd,
  input  wire logic        i_reg_wr,
  input  wire logic [15:0] i_reg_num,
  input  wire logic [15:0] i_reg_wdata,
  output      logic [15:0] o_reg_rdata,
  output      logic        o_reg_hit,
  input  wire logic [9:0]  i_analog_one,
  input  wire logic [9:0]  i_analog_two,
  input  wire logic [9:0]  i_analog_three,
  input  wire logic [1:0]  i_chan_one_phase,
  input  wire logic [7:0]  i_din_pins,
  input  wire logic [7:0]  i_dout_value,
  input  wire logic        i_index_pulse,
  output      logic [7:0]  o_dout_pins,
  output      logic [7:0]  o_din_value
);

  // ==========================================================================
  // configuration registers
  logic [15:0] primary_ff;
  logic [15:0] secondary_ff;

  // software writes; reserved bits of the secondary config stay zero
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      primary_ff   <= ioc_pkg::PRIMARY_RESET;
      secondary_ff <= ioc_pkg::SECONDARY_RESET;
    end
    else if (i_reg_wr)
    begin
      if (i_reg_num == ioc_pkg::REG_PRIMARY_CONFIG)
        primary_ff <= i_reg_wdata;
      if (i_reg_num == ioc_pkg::REG_SECONDARY_CONFIG)
        secondary_ff <= i_reg_wdata & ioc_pkg::CONFIG_WRITE_MASK;
    end
  end

  logic analog_use_bit;
  logic channel_one_use_bit;
  logic channel_two_use_bit;
  logic channel_one_fine_select;
  logic channel_two_fine_select;
  logic matrix_scan_bit;
  logic period_measure_disable;
  logic spindle_iface_disable;
  assign analog_use_bit          = primary_ff[ioc_pkg::ANALOG_USE_POS];
  assign channel_one_use_bit     = secondary_ff[ioc_pkg::CHAN_ONE_USE_POS];
  assign channel_two_use_bit     = secondary_ff[ioc_pkg::CHAN_TWO_USE_POS];
  assign channel_one_fine_select = secondary_ff[ioc_pkg::CHAN_ONE_FINE_POS];
  assign channel_two_fine_select = secondary_ff[ioc_pkg::CHAN_TWO_FINE_POS];
  assign matrix_scan_bit         = secondary_ff[ioc_pkg::MATRIX_SCAN_POS];
  assign period_measure_disable  = secondary_ff[ioc_pkg::PERIOD_DISABLE_POS];
  assign spindle_iface_disable   = secondary_ff[ioc_pkg::SPINDLE_DISABLE_POS];

  // ==========================================================================
  // analog sample capture
  logic [9:0] analog_ff [3];

  // results frozen while analog input is switched off
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      analog_ff[0] <= 10'h000;
      analog_ff[1] <= 10'h000;
      analog_ff[2] <= 10'h000;
    end
    else if (analog_use_bit)
    begin
      analog_ff[0] <= i_analog_one;
      analog_ff[1] <= i_analog_two;
      analog_ff[2] <= i_analog_three;
    end
  end

  // ==========================================================================
  // pulse generator counters
  logic        rd_count_one;
  logic        rd_count_two;
  logic [15:0] count_one;
  logic [15:0] count_two;
  logic [1:0]  chan_two_phase;

  assign rd_count_one   = i_reg_rd && i_reg_num == ioc_pkg::REG_PULSE_GEN_ONE;
  assign rd_count_two   = i_reg_rd && i_reg_num == ioc_pkg::REG_PULSE_GEN_TWO;
  assign chan_two_phase = i_din_pins[5:4];

  ioc_quad_counter u_chan_one
  (
    .i_clk_sys   (i_clk_sys),
    .i_reset     (i_reset),
    .i_enable    (channel_one_use_bit),
    .i_fine      (channel_one_fine_select),
    .i_phase     (i_chan_one_phase),
    .o_count     (count_one)
  );

  ioc_quad_counter u_chan_two
  (
    .i_clk_sys   (i_clk_sys),
    .i_reset     (i_reset),
    .i_enable    (channel_two_use_bit),
    .i_fine      (channel_two_fine_select),
    .i_phase     (chan_two_phase),
    .o_count     (count_two)
  );

  // ==========================================================================
  // tick divider shared by interval and period timers
  logic [7:0] tick_div_ff;
  logic       tick;
  assign tick = tick_div_ff == ioc_pkg::TICK_LAST;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || tick)
      tick_div_ff <= 8'h00;
    else
      tick_div_ff <= tick_div_ff + 8'h01;
  end

  // ticks since last counter read, saturating
  logic [15:0] interval_ff;
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || rd_count_one || rd_count_two)
      interval_ff <= 16'h0000;
    else if (tick && interval_ff != 16'hFFFF)
      interval_ff <= interval_ff + 16'h0001;
  end

  // ==========================================================================
  // index pulse period measurement
  logic        index_sync_ff;
  logic        index_meta_ff;
  logic        index_last_ff;
  logic [15:0] period_run_ff;
  logic [15:0] period_ff;
  logic        index_rise;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      index_meta_ff <= 1'b0;
      index_sync_ff <= 1'b0;
      index_last_ff <= 1'b0;
    end
    else
    begin
      index_meta_ff <= i_index_pulse;
      index_sync_ff <= index_meta_ff;
      index_last_ff <= index_sync_ff;
    end
  end

  assign index_rise = index_sync_ff && !index_last_ff;

  // latch running time on each rising index edge, then restart
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      period_run_ff <= 16'h0000;
      period_ff     <= 16'h0000;
    end
    else if (!period_measure_disable && !spindle_iface_disable)
    begin
      if (index_rise)
      begin
        period_ff     <= period_run_ff;
        period_run_ff <= 16'h0000;
      end
      else if (tick && period_run_ff != 16'hFFFF)
        period_run_ff <= period_run_ff + 16'h0001;
    end
  end

  // ==========================================================================
  // switch matrix scanner
  ioc_pkg::ioc_scan_type scan_state_ff;
  logic [1:0]  column_ff;
  logic [7:0]  settle_ff;
  logic [15:0] matrix_ff;
  logic [3:0]  strobe_ff;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || !matrix_scan_bit)
    begin
      scan_state_ff <= ioc_pkg::SCAN_SETTLE;
      column_ff     <= 2'h0;
      settle_ff     <= 8'h00;
    end
    else
    begin
      case (scan_state_ff)
        ioc_pkg::SCAN_SETTLE:
        begin
          settle_ff <= settle_ff + 8'h01;
          if (settle_ff == ioc_pkg::SETTLE_LAST)
            scan_state_ff <= ioc_pkg::SCAN_SAMPLE;
        end
        ioc_pkg::SCAN_SAMPLE:
        begin
          settle_ff     <= 8'h00;
          column_ff     <= column_ff + 2'h1;
          scan_state_ff <= ioc_pkg::SCAN_SETTLE;
        end
        default:
          scan_state_ff <= ioc_pkg::SCAN_SETTLE;
      endcase
    end
  end

  // one-hot column strobe, rows stored per column independently
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || !matrix_scan_bit)
    begin
      matrix_ff <= 16'h0000;
      strobe_ff <= 4'h0;
    end
    else
    begin
      strobe_ff <= 4'h1 << column_ff;
      if (scan_state_ff == ioc_pkg::SCAN_SAMPLE)
        matrix_ff[{column_ff, 2'b00} +: 4] <= i_din_pins[3:0];
    end
  end

  // ==========================================================================
  // discrete pin sharing
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_dout_pins <= 8'h00;
      o_din_value <= 8'h00;
    end
    else
    begin
      o_dout_pins <= matrix_scan_bit ?
        {i_dout_value[7:4], strobe_ff} : i_dout_value;
      o_din_value <= {i_din_pins[7:6],
        channel_two_use_bit ? 2'b00 : i_din_pins[5:4],
        matrix_scan_bit ? 4'h0 : i_din_pins[3:0]};
    end
  end

  // ==========================================================================
  // register read port, answer one cycle after the request
  logic [15:0] nxt_rdata;
  logic        nxt_hit;
  always_comb
  begin
    nxt_hit   = 1'b1;
    nxt_rdata = 16'h0000;
    case (i_reg_num)
      ioc_pkg::REG_PRIMARY_CONFIG:   nxt_rdata = primary_ff;
      ioc_pkg::REG_SECONDARY_CONFIG: nxt_rdata = secondary_ff;
      ioc_pkg::REG_PULSE_GEN_ONE:    nxt_rdata = count_one;
      ioc_pkg::REG_PULSE_GEN_TWO:    nxt_rdata = count_two;
      ioc_pkg::REG_ANALOG_ONE:       nxt_rdata = {6'h00, analog_ff[0]};
      ioc_pkg::REG_ANALOG_TWO:       nxt_rdata = {6'h00, analog_ff[1]};
      ioc_pkg::REG_ANALOG_THREE:     nxt_rdata = {6'h00, analog_ff[2]};
      ioc_pkg::REG_READ_INTERVAL:    nxt_rdata = interval_ff;
      ioc_pkg::REG_INDEX_INTERVAL:   nxt_rdata = period_ff;
      ioc_pkg::REG_SWITCH_MATRIX:    nxt_rdata = matrix_ff;
      default:                       nxt_hit   = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_reg_rdata <= 16'h0000;
      o_reg_hit   <= 1'b0;
    end
    else
    begin
      o_reg_rdata <= i_reg_rd ? nxt_rdata : 16'h0000;
      o_reg_hit   <= i_reg_rd && nxt_hit;
    end
  end

endmodule

// quadrature decoder with 16-bit wrapping up/down count
module ioc_quad_counter
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  input  wire logic        i_enable,
  input  wire logic        i_fine,
  input  wire logic [1:0]  i_phase,
  output      logic [15:0] o_count
);
  logic [1:0]  meta_ff;
  logic [1:0]  sync_ff;
  logic [1:0]  last_ff;
  logic [15:0] count_ff;
  logic        step;
  logic        up;

  // two-stage synchroniser then previous sample
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      meta_ff <= 2'b00;
      sync_ff <= 2'b00;
      last_ff <= 2'b00;
    end
    else
    begin
      meta_ff <= i_phase;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  // single-bit gray step is valid; a leading b gives up
  assign step = ^(sync_ff ^ last_ff);
  assign up   = last_ff[0] ^ sync_ff[1];

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      count_ff <= 16'h0000;
    else if (i_enable && step)
      count_ff <= up ? count_ff + 16'h0001 : count_ff - 16'h0001;
  end

  // coarse mode reports count divided by four
  assign o_count = i_fine ? count_ff : {2'b00, count_ff[15:2]};
endmodule

// file: verif/ioc_input_capture_checker.sv
// port-level assertions for the input capture block
module ioc_input_capture_checker
(
  input wire logic        i_clk_sys,
  input wire logic        i_reset,
  input wire logic        i_reg_rd,
  input wire logic        i_reg_wr,
  input wire logic [15:0] i_reg_num,
  input wire logic [15:0] i_reg_wdata,
  input wire logic [15:0] o_reg_rdata,
  input wire logic        o_reg_hit,
  input wire logic [7:0]  o_dout_pins,
  input wire logic [7:0]  o_din_value
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0][7:0] sec_ff;
  logic            steady;
  logic [3:0]      cols;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // ==========================================================
  // shadow of the secondary config with a short history
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      sec_ff <= {4{8'h0F}};
    else if (i_reg_wr && i_reg_num == ioc_pkg::REG_SECONDARY_CONFIG)
      sec_ff <= {sec_ff[2:0], i_reg_wdata[7:0] & 8'hEF};
    else
      sec_ff <= {sec_ff[2:0], sec_ff[0]};
  end
  // settings unchanged for three cycles, so outputs have caught up
  assign steady = (sec_ff[0] == sec_ff[3]);
  assign cols = o_dout_pins[3:0];
  sequence s_count_read;
    i_reg_rd && i_reg_num == ioc_pkg::REG_PULSE_GEN_ONE;
  endsequence
  sequence s_interval_read;
    i_reg_rd && i_reg_num == ioc_pkg::REG_READ_INTERVAL;
  endsequence
  // ==========================================================
  // assertions
  a_analog_right: assert property (i_reg_rd
    && i_reg_num >= ioc_pkg::REG_ANALOG_ONE
    && i_reg_num <= ioc_pkg::REG_ANALOG_THREE
    |=> o_reg_hit && o_reg_rdata[15:10] == 6'h00)
    else $error("analog read malformed");
  a_unmapped_quiet: assert property (i_reg_rd
    && i_reg_num > ioc_pkg::REG_SWITCH_MATRIX
    |=> !o_reg_hit && o_reg_rdata == 16'h0000)
    else $error("unmapped read answered");
  a_second_value: assert property (i_reg_rd
    && i_reg_num == ioc_pkg::REG_SECONDARY_CONFIG
    |=> o_reg_rdata == {8'h00, $past(sec_ff[0])})
    else $error("secondary config readback wrong");
  a_interval_restart: assert property (
    s_count_read ##1 s_interval_read |=> o_reg_rdata == 16'h0000)
    else $error("interval not restarted");
  a_column_onehot: assert property (
    steady && sec_ff[0][5] |-> $onehot0(cols))
    else $error("more than one column strobe");
  a_rows_masked: assert property (
    steady && sec_ff[0][5] |-> o_din_value[3:0] == 4'h0)
    else $error("row inputs leak into discrete inputs");
  a_chan_two_mask: assert property (
    steady && sec_ff[0][1] |-> o_din_value[5:4] == 2'b00)
    else $error("channel two pins leak into discrete inputs");
  a_strobe_settle: assert property (
    steady && sec_ff[0][5] && $changed(cols) && cols != 4'h0
    |=> ($stable(cols) || !sec_ff[0][5]) [*8])
    else $error("column strobe too short");
endmodule

bind ioc_input_capture ioc_input_capture_checker u_chk (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_reg_rd(i_reg_rd),
  .i_reg_wr(i_reg_wr), .i_reg_num(i_reg_num),
  .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .o_reg_hit(o_reg_hit), .o_dout_pins(o_dout_pins),
  .o_din_value(o_din_value));

// file: verif/ioc_far_side.sv
// far side model: diode switch matrix on the column strobes
module ioc_far_side
(
  input  wire logic [3:0]  i_columns,
  input  wire logic [15:0] i_closed,
  output      logic [3:0]  o_rows
);
  timeunit 1ns;
  timeprecision 1ns;
  // a closed switch joins column to row through its diode; rows pull low
  always_comb
  begin
    o_rows = 4'h0;
    for (int c = 0; c < 4; c++)
      for (int r = 0; r < 4; r++)
        if (i_columns[c] && i_closed[4*c+r])
          o_rows[r] = 1'b1;
  end
endmodule

// file: verif/tb.sv
// self-checking bench for the input capture block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk_sys;
  logic        i_reset;
  logic        i_reg_rd;
  logic        i_reg_wr;
  logic [15:0] i_reg_num;
  logic [15:0] i_reg_wdata;
  logic [15:0] o_reg_rdata;
  logic        o_reg_hit;
  logic [9:0]  ana [3];
  logic [1:0]  i_chan_one_phase;
  logic [3:0]  din_hi;
  logic [3:0]  rows;
  logic [7:0]  i_din_pins;
  logic [7:0]  i_dout_value;
  logic        i_index_pulse;
  logic [7:0]  o_dout_pins;
  logic [7:0]  o_din_value;
  logic [15:0] closed;
  logic [1:0]  gray [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
  int          pos [2] = '{0, 0};
  int          n_mismatch = 0;
  int          check_count = 0;
  int          cyc = 0;
  assign i_din_pins = {din_hi, rows};
  ioc_input_capture dut (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_reg_rd(i_reg_rd),
    .i_reg_wr(i_reg_wr), .i_reg_num(i_reg_num),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_reg_hit(o_reg_hit), .i_analog_one(ana[0]),
    .i_analog_two(ana[1]), .i_analog_three(ana[2]),
    .i_chan_one_phase(i_chan_one_phase), .i_din_pins(i_din_pins),
    .i_dout_value(i_dout_value), .i_index_pulse(i_index_pulse),
    .o_dout_pins(o_dout_pins), .o_din_value(o_din_value));
  ioc_far_side far (.i_columns(o_dout_pins[3:0]), .i_closed(closed),
    .o_rows(rows));
  // ==========================================================
  // clock and hang guard
  initial
  begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  // ==========================================================
  // tasks
  task automatic conclude();
    if (n_mismatch == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // read one register and compare the answer of the next cycle
  task automatic rc(input string nm, input logic [15:0] n,
                    input logic [15:0] e);
    @(posedge i_clk_sys);
    i_reg_rd  <= 1'b1;
    i_reg_num <= n;
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b0;
    #1 chk(nm, e, o_reg_rdata);
  endtask
  // read count one, then the interval register on the very next cycle
  task automatic rb(input logic [15:0] e);
    @(posedge i_clk_sys);
    i_reg_rd  <= 1'b1;
    i_reg_num <= ioc_pkg::REG_PULSE_GEN_ONE;
    @(posedge i_clk_sys);
    i_reg_num <= ioc_pkg::REG_READ_INTERVAL;
    #1 chk("count one", e, o_reg_rdata);
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b0;
    #1 chk("interval", 16'h0000, o_reg_rdata);
  endtask
  task automatic wr(input logic [15:0] n, input logic [15:0] v);
    @(posedge i_clk_sys);
    i_reg_wr    <= 1'b1;
    i_reg_num   <= n;
    i_reg_wdata <= v;
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
  endtask
  // move one encoder by n quadrature steps, dir +1 up or -1 down
  // phase b leads when counting up; each phase is held past sync latency
  task automatic step(input int ch, input int dir, input int n);
    repeat (n)
    begin
      pos[ch] = (pos[ch] + dir + 4) % 4;
      @(posedge i_clk_sys);
      if (ch == 0)
        i_chan_one_phase <= gray[pos[ch]];
      else
        din_hi[1:0] <= gray[pos[ch]];
      repeat (8) @(posedge i_clk_sys);
    end
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    i_reset = 1'b1;
    i_reg_rd = 1'b0;
    i_reg_wr = 1'b0;
    i_reg_num = 16'h0000;
    i_reg_wdata = 16'h0000;
    ana = '{10'h3FF, 10'h000, 10'h155};
    i_chan_one_phase = 2'b00;
    din_hi = 4'hC;
    i_dout_value = 8'h5A;
    i_index_pulse = 1'b0;
    closed = 16'h0000;
    repeat (6) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    rc("primary", ioc_pkg::REG_PRIMARY_CONFIG, 16'h0002);
    rc("secondary", ioc_pkg::REG_SECONDARY_CONFIG, 16'h000F);
    chk("dout pins", 16'h005A, {8'h00, o_dout_pins});
    rc("unmapped", 16'h0487, 16'h0000);
    chk("hit unmapped", 16'h0000, {15'h0000, o_reg_hit});
    rc("analog one", ioc_pkg::REG_ANALOG_ONE, 16'h03FF);
    chk("hit mapped", 16'h0001, {15'h0000, o_reg_hit});
    rc("analog two", ioc_pkg::REG_ANALOG_TWO, 16'h0000);
    rc("analog three", ioc_pkg::REG_ANALOG_THREE, 16'h0155);
    wr(ioc_pkg::REG_PRIMARY_CONFIG, 16'h0000);
    ana[0] <= 10'h001;
    repeat (4) @(posedge i_clk_sys);
    rc("analog held", ioc_pkg::REG_ANALOG_ONE, 16'h03FF);
    wr(ioc_pkg::REG_PRIMARY_CONFIG, 16'h0002);
    repeat (4) @(posedge i_clk_sys);
    rc("analog live", ioc_pkg::REG_ANALOG_ONE, 16'h0001);
    // two index edges 501 cycles apart span exactly two ticks
    @(posedge i_clk_sys);
    i_index_pulse <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    i_index_pulse <= 1'b0;
    repeat (497) @(posedge i_clk_sys);
    i_index_pulse <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    i_index_pulse <= 1'b0;
    rc("index period", ioc_pkg::REG_INDEX_INTERVAL, 16'h0002);
    step(0, 1, 4);
    rb(16'h0004);
    // 500 cycles from the restart to the next read: two whole ticks
    repeat (498) @(posedge i_clk_sys);
    rc("interval", ioc_pkg::REG_READ_INTERVAL, 16'h0002);
    step(0, -1, 5);
    rc("count wrap", ioc_pkg::REG_PULSE_GEN_ONE, 16'hFFFF);
    step(1, 1, 3);
    #1 chk("din value", 16'h00C0, {8'h00, o_din_value});
    rc("count two", ioc_pkg::REG_PULSE_GEN_TWO, 16'h0003);
    wr(ioc_pkg::REG_SECONDARY_CONFIG, 16'h0003);
    rc("coarse one", ioc_pkg::REG_PULSE_GEN_ONE, 16'h3FFF);
    wr(ioc_pkg::REG_SECONDARY_CONFIG, 16'h000E);
    step(0, 1, 2);
    rc("held one", ioc_pkg::REG_PULSE_GEN_ONE, 16'hFFFF);
    rc("secondary", ioc_pkg::REG_SECONDARY_CONFIG, 16'h000E);
    closed <= 16'hA5C3;
    wr(ioc_pkg::REG_SECONDARY_CONFIG, 16'hFFFF);
    rc("secondary", ioc_pkg::REG_SECONDARY_CONFIG, 16'h00EF);
    repeat (2100) @(posedge i_clk_sys);
    rc("matrix", ioc_pkg::REG_SWITCH_MATRIX, 16'hA5C3);
    chk("din rows", 16'h0000, {12'h000, o_din_value[3:0]});
    chk("dout high", 16'h0005, {12'h000, o_dout_pins[7:4]});
    wr(ioc_pkg::REG_SECONDARY_CONFIG, 16'h000F);
    repeat (4) @(posedge i_clk_sys);
    rc("matrix off", ioc_pkg::REG_SWITCH_MATRIX, 16'h0000);
    chk("dout pins", 16'h005A, {8'h00, o_dout_pins});
    conclude();
  end
endmodule
